// ===== rtl/ipec_pkg.sv
package ipec_pkg;
  // Register word indices; the bus byte address is the index times four
  localparam logic [11:0] IPEC_IDX_PRIO_HIGH = 12'hfc7;
  localparam logic [11:0] IPEC_IDX_PRIO_LOW  = 12'hfc8;
  localparam logic [11:0] IPEC_IDX_EDGE_SEL  = 12'hfcd;
  localparam logic [11:0] IPEC_IDX_SHARED    = 12'hfce;
  localparam logic [11:0] IPEC_IDX_MASTER    = 12'hfcf;
  localparam logic [11:0] IPEC_IDX_STATUS    = 12'hfd0;
  localparam logic [11:0] IPEC_IDX_MASK      = 12'hfd1;
  localparam logic [11:0] IPEC_IDX_PENDING   = 12'hfd2;
  localparam int          IPEC_ADDR_W        = 14;
  // Field positions
  localparam int          IPEC_MIE_BIT       = 7;
  localparam int          IPEC_SRC_SEL_BIT   = 6;
  localparam int          IPEC_PRIO_BITS     = 4;
  // Reset values and writable masks
  localparam logic [7:0]  IPEC_RST_VAL       = 8'h00;
  localparam logic [7:0]  IPEC_PRIO_WMASK    = 8'h0f;
  localparam logic [7:0]  IPEC_SHARED_WMASK  = 8'h40;
  localparam logic [7:0]  IPEC_MASTER_WMASK  = 8'h80;
  localparam logic [7:0]  IPEC_STAT_WMASK    = 8'h0f;

  typedef enum logic [1:0]
  {
    IPEC_LVL_OFF = 2'b00,
    IPEC_LVL_1   = 2'b01,
    IPEC_LVL_2   = 2'b10,
    IPEC_LVL_3   = 2'b11
  } ipec_level_t;

  typedef enum logic [0:0]
  {
    IPEC_BUS_IDLE = 1'b0,
    IPEC_BUS_ACK  = 1'b1
  } ipec_bus_t;
endpackage : ipec_pkg

// ===== rtl/ipec_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
// Edge detector carrier: sampled levels in, polarity in, events out
interface ipec_edge_if #(parameter int N = 8);
  logic [N-1:0] level;
  logic [N-1:0] polarity;
  logic [N-1:0] event_hit;
  modport det (input level, input polarity, output event_hit);
  modport user (output level, output polarity, input event_hit);
endinterface : ipec_edge_if
`default_nettype wire

// ===== rtl/ipec_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
module ipec_edge_det #(
  parameter int N = 8
) (
  input  wire logic clk,
  input  wire logic rst,
  ipec_edge_if.det  eif
);
  logic [N-1:0] prev_q;

  // Previous level, one per input
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prev_q <= '0;
    else
      prev_q <= eif.level;
  end

  // Per-pin polarity: one = rising, zero = falling
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_edge
      assign eif.event_hit[g] = eif.polarity[g] ? (eif.level[g] & ~prev_q[g])
                                                : (~eif.level[g] & prev_q[g]);
    end
  endgenerate
endmodule : ipec_edge_det
`default_nettype wire

// ===== rtl/ipec_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// (R1) Two enable bits encode priority level zero-three
// (R2) High enable register: port C bits 3:0
// (R3) Low enable register: port C bits 3:0
// (R4) Edge select bit: zero falling, one rising
// (R5) Select bit zero: shared request from pin
// (R6) Select bit one: shared request from comparator
// (R7) Shared request is edge detected after mux
// (R8) Software disables interrupt before switching source
// (R9) Master enable set by enable, return, write
// (R10) Master enable cleared by disable, acknowledge, write
// (R11) Master enable gates every interrupt presented; code gates IRQ_VALID only, INT_O and edge requests are not gated
// (R12) Control bits 6:0 read as zero
// (R13) Highest level wins, lowest index breaks ties
module ipec_ctrl
  import ipec_pkg::*;
#(
  parameter int EDGE_PINS = 8
) (
  input  wire logic                          REF_CLK,
  input  wire logic                          RST,
  input  wire logic                          WB_CYC_I,
  input  wire logic                          WB_STB_I,
  input  wire logic                          WB_WE_I,
  input  wire logic [ipec_pkg::IPEC_ADDR_W-1:0] WB_ADR_I,
  input  wire logic [31:0]                   WB_DAT_I,
  input  wire logic [3:0]                    WB_SEL_I,
  output logic      [31:0]                   WB_DAT_O,
  output logic                               WB_ACK_O,
  input  wire logic [EDGE_PINS-1:0]          PORTA_PINS,
  input  wire logic [EDGE_PINS-1:0]          PORTD_PINS,
  input  wire logic [3:0]                    PORTC_PINS,
  input  wire logic                          COMPARATOR_OUT,
  input  wire logic                          ENABLE_INTERRUPTS_INSTRUCTION,
  input  wire logic                          DISABLE_INTERRUPTS_INSTRUCTION,
  input  wire logic                          INTERRUPT_RETURN_INSTRUCTION,
  input  wire logic                          IRQ_ACK,
  output logic                               IRQ_VALID,
  output logic      [1:0]                    IRQ_LEVEL,
  output logic      [3:0]                    IRQ_SOURCE,
  output logic      [EDGE_PINS-1:0]          EDGE_REQUESTS,
  output logic                               SHARED_REQUEST,
  output logic                               INT_O
);
  import ipec_pkg::*;

  // Elaboration check: the edge select register is one byte wide
  if (EDGE_PINS != 8)
  begin : g_bad_pins
    $error("EDGE_PINS must be 8 to match the 8-bit edge select register");
  end

  logic [7:0]  prio_high_q, prio_low_q, edge_sel_q, shared_q;
  logic        mie_q;
  logic [3:0]  status_q, mask_q;
  logic [3:0]  portc_prev_q;
  logic        shared_prev_q;
  ipec_bus_t   bus_q;
  logic [31:0] rdata_d;
  logic        access, wr, wr_low;
  logic [11:0] idx;
  logic [3:0]  portc_ev;
  logic        shared_sel, shared_ev;

  ipec_edge_if #(.N(EDGE_PINS)) eif ();

  // Wishbone decode: word index is the byte address over four
  assign idx    = WB_ADR_I[IPEC_ADDR_W-1:2];
  assign access = WB_CYC_I & WB_STB_I & (bus_q == IPEC_BUS_IDLE);
  assign wr     = access & WB_WE_I;
  assign wr_low = wr & WB_SEL_I[0];

  // Classic handshake: ack one cycle after the strobe, then drop
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      bus_q    <= IPEC_BUS_IDLE;
      WB_ACK_O <= 1'b0;
    end
    else
    begin
      WB_ACK_O <= access;
      bus_q    <= access ? IPEC_BUS_ACK : IPEC_BUS_IDLE;
    end
  end

  // Priority enable registers, reserved upper bits held at zero
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      prio_high_q <= IPEC_RST_VAL;
      prio_low_q  <= IPEC_RST_VAL;
    end
    else if (wr_low)
    begin
      // (R2) high enable write
      if (idx == IPEC_IDX_PRIO_HIGH)
        prio_high_q <= WB_DAT_I[7:0] & IPEC_PRIO_WMASK;
      // (R3) low enable write
      if (idx == IPEC_IDX_PRIO_LOW)
        prio_low_q <= WB_DAT_I[7:0] & IPEC_PRIO_WMASK;
    end
  end

  // Edge and shared source selection
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      edge_sel_q <= IPEC_RST_VAL;
      shared_q   <= IPEC_RST_VAL;
    end
    else if (wr_low)
    begin
      // (R4) edge polarity per pin
      if (idx == IPEC_IDX_EDGE_SEL)
        edge_sel_q <= WB_DAT_I[7:0];
      if (idx == IPEC_IDX_SHARED)
        shared_q <= WB_DAT_I[7:0] & IPEC_SHARED_WMASK;
    end
  end

  // Master enable; instructions, ack and direct writes all steer it
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      mie_q <= 1'b0;
    // (R10) acknowledge and disable clear first
    else if (IRQ_ACK || DISABLE_INTERRUPTS_INSTRUCTION)
      mie_q <= 1'b0;
    // (R9) enable or return instruction set
    else if (ENABLE_INTERRUPTS_INSTRUCTION || INTERRUPT_RETURN_INSTRUCTION)
      mie_q <= 1'b1;
    // (R9) direct write
    else if (wr_low && idx == IPEC_IDX_MASTER)
      mie_q <= WB_DAT_I[IPEC_MIE_BIT];
  end

  // Port A / port D edge detection: A and D pins ORed bit by bit, D pins share polarity
  assign eif.level    = PORTA_PINS | PORTD_PINS;
  assign eif.polarity = edge_sel_q;

  ipec_edge_det #(.N(EDGE_PINS)) u_edge (
    .clk (REF_CLK),
    .rst (RST),
    .eif (eif)
  );

  // (R5) pin chosen when select bit is zero
  // (R6) comparator chosen when select bit is one
  assign shared_sel = shared_q[IPEC_SRC_SEL_BIT] ? COMPARATOR_OUT : PORTA_PINS[6];

  // (R7) edge taken after the mux, so a switch can itself fire
  assign shared_ev = edge_sel_q[6] ? (shared_sel & ~shared_prev_q) : (~shared_sel & shared_prev_q);

  // Port C edges use rising edge; previous levels held here
  assign portc_ev = PORTC_PINS & ~portc_prev_q;

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      portc_prev_q  <= 4'h0;
      shared_prev_q <= 1'b0;
    end
    else
    begin
      portc_prev_q  <= PORTC_PINS;
      shared_prev_q <= shared_sel;
    end
  end

  // Sticky port C request status; a new edge wins over a write-one clear
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      status_q <= 4'h0;
    else if (wr_low && idx == IPEC_IDX_STATUS)
      status_q <= (status_q & ~(WB_DAT_I[3:0] & IPEC_STAT_WMASK[3:0])) | portc_ev;
    else
      status_q <= status_q | portc_ev;
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      mask_q <= 4'h0;
    else if (wr_low && idx == IPEC_IDX_MASK)
      mask_q <= WB_DAT_I[3:0];
  end

  // Arbitration over the four port C requests
  ipec_level_t lvl [4];
  ipec_level_t best_lvl;
  logic [3:0]  best_src;
  genvar gi;
  generate
    for (gi = 0; gi < IPEC_PRIO_BITS; gi++)
    begin : g_lvl
      // (R1) high/low pair forms the level
      assign lvl[gi] = ipec_level_t'({prio_high_q[gi], prio_low_q[gi]});
    end
  endgenerate

  always_comb
  begin
    best_lvl = IPEC_LVL_OFF;
    best_src = 4'h0;
    // (R13) strictly greater keeps the lowest index on ties
    for (int i = 0; i < IPEC_PRIO_BITS; i++)
    begin
      if (status_q[i] && lvl[i] > best_lvl)
      begin
        best_lvl = lvl[i];
        best_src = 4'(i);
      end
    end
  end

  // Request to the core, all registered
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      IRQ_VALID      <= 1'b0;
      IRQ_LEVEL      <= 2'b00;
      IRQ_SOURCE     <= 4'h0;
      EDGE_REQUESTS  <= '0;
      SHARED_REQUEST <= 1'b0;
      INT_O          <= 1'b0;
    end
    else
    begin
      // (R11) IRQ_VALID is low from the cycle after master enable goes low; INT_O and the edge requests are not gated
      IRQ_VALID      <= mie_q && (best_lvl != IPEC_LVL_OFF) && !IRQ_ACK;
      IRQ_LEVEL      <= best_lvl;
      IRQ_SOURCE     <= best_src;
      EDGE_REQUESTS  <= eif.event_hit;
      SHARED_REQUEST <= shared_ev;
      INT_O          <= |((status_q | portc_ev) & mask_q);
    end
  end

  // Read mux; unmapped reads return zero
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    unique case (idx)
      IPEC_IDX_PRIO_HIGH: rdata_d[7:0] = prio_high_q;
      IPEC_IDX_PRIO_LOW:  rdata_d[7:0] = prio_low_q;
      IPEC_IDX_EDGE_SEL:  rdata_d[7:0] = edge_sel_q;
      IPEC_IDX_SHARED:    rdata_d[7:0] = shared_q;
      // (R12) low bits always zero
      IPEC_IDX_MASTER:    rdata_d[7:0] = {mie_q, 7'h00};
      IPEC_IDX_STATUS:    rdata_d[3:0] = status_q;
      IPEC_IDX_MASK:      rdata_d[3:0] = mask_q;
      IPEC_IDX_PENDING:   rdata_d[3:0] = status_q & mask_q;
      default:            rdata_d      = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      WB_DAT_O <= 32'h0000_0000;
    else if (access)
      WB_DAT_O <= rdata_d;
  end

  // Assertions
  // (R10)
  chk_ack_clears_mie: assert property (@(posedge REF_CLK) disable iff (RST) // (R10)
    IRQ_ACK |=> !mie_q) else $error("master enable survived acknowledge");
  chk_ei_sets_mie: assert property (@(posedge REF_CLK) disable iff (RST) // (R9)
    (ENABLE_INTERRUPTS_INSTRUCTION && !IRQ_ACK && !DISABLE_INTERRUPTS_INSTRUCTION) |=> mie_q)
    else $error("enable instruction did not set master enable");
  chk_mie_gates_irq: assert property (@(posedge REF_CLK) disable iff (RST) // (R11)
    !$past(mie_q) |-> !IRQ_VALID) else $error("request presented while disabled");
  chk_reserved_high: assert property (@(posedge REF_CLK) disable iff (RST) // (R2)
    prio_high_q[7:4] == 4'h0) else $error("reserved high enable bits set");
  chk_reserved_low: assert property (@(posedge REF_CLK) disable iff (RST) // (R3)
    prio_low_q[7:4] == 4'h0) else $error("reserved low enable bits set");
  chk_ctrl_read_zero: assert property (@(posedge REF_CLK) disable iff (RST) // (R12)
    (WB_ACK_O && $past(idx) == IPEC_IDX_MASTER && !$past(WB_WE_I)) |-> WB_DAT_O[6:0] == 7'h00)
    else $error("control reserved bits not zero");
  chk_shared_comp: assert property (@(posedge REF_CLK) disable iff (RST) // (R6)
    (shared_q[IPEC_SRC_SEL_BIT] && $rose(COMPARATOR_OUT) && edge_sel_q[6] && $stable(shared_q))
    |=> SHARED_REQUEST) else $error("comparator edge missed");
  chk_level_encode: assert property (@(posedge REF_CLK) disable iff (RST) // (R1)
    IRQ_VALID |-> IRQ_LEVEL == {$past(prio_high_q[best_src[1:0]], 1), $past(prio_low_q[best_src[1:0]], 1)})
    else $error("level encoding wrong");
  chk_ack_one_cycle: assert property (@(posedge REF_CLK) disable iff (RST)
    WB_ACK_O |=> !WB_ACK_O) else $error("ack held longer than a cycle");
  // Shared path: pin edge passes while the pin is selected
  chk_pin_select: assert property (@(posedge REF_CLK) disable iff (RST) // (R5)
    (!shared_q[IPEC_SRC_SEL_BIT] && $rose(PORTA_PINS[6]) && edge_sel_q[6] && $stable(shared_q))
    |=> SHARED_REQUEST) else $error("shared pin edge missed");
  // A source switch that makes an edge must be reported too
  chk_switch_edge: assert property (@(posedge REF_CLK) disable iff (RST) // (R7)
    (edge_sel_q[6] && $rose(shared_sel)) |=> SHARED_REQUEST)
    else $error("edge after source switch missed");
  // Pin detector honours the polarity bit in both directions
  chk_edge_rise: assert property (@(posedge REF_CLK) disable iff (RST) // (R4)
    (eif.polarity[0] && $rose(eif.level[0])) |=> EDGE_REQUESTS[0])
    else $error("rising pin edge missed");
  chk_edge_fall: assert property (@(posedge REF_CLK) disable iff (RST) // (R4)
    (!eif.polarity[0] && $fell(eif.level[0])) |=> EDGE_REQUESTS[0])
    else $error("falling pin edge missed");
  // High enable write lands on the next edge
  chk_wr_high: assert property (@(posedge REF_CLK) disable iff (RST) // (R2)
    (wr_low && idx == IPEC_IDX_PRIO_HIGH) |=> prio_high_q[3:0] == $past(WB_DAT_I[3:0]))
    else $error("high enable write lost");
  // A direct write steers the master enable when no instruction competes
  chk_mie_write: assert property (@(posedge REF_CLK) disable iff (RST) // (R9)
    (wr_low && idx == IPEC_IDX_MASTER && !IRQ_ACK && !DISABLE_INTERRUPTS_INSTRUCTION
     && !ENABLE_INTERRUPTS_INSTRUCTION && !INTERRUPT_RETURN_INSTRUCTION)
    |=> mie_q == $past(WB_DAT_I[IPEC_MIE_BIT])) else $error("master enable write lost");
  // Equal levels: the lower source index must win
  chk_tie_lowest: assert property (@(posedge REF_CLK) disable iff (RST) // (R13)
    (status_q[0] && status_q[1] && lvl[0] == lvl[1] && lvl[0] != IPEC_LVL_OFF)
    |=> IRQ_SOURCE != 4'h1) else $error("tie not broken toward lower index");
  // Status stays set until software clears it
  chk_status_sticky: assert property (@(posedge REF_CLK) disable iff (RST)
    (status_q[0] && !(wr_low && idx == IPEC_IDX_STATUS)) |=> status_q[0])
    else $error("status bit lost without clear");
  cov_irq_l3: cover property (@(posedge REF_CLK) disable iff (RST) IRQ_VALID && IRQ_LEVEL == 2'b11);
  cov_edge_req: cover property (@(posedge REF_CLK) disable iff (RST) EDGE_REQUESTS != 8'h00);
  cov_ack_path: cover property (@(posedge REF_CLK) disable iff (RST) IRQ_VALID ##1 IRQ_ACK);
  cov_shared: cover property (@(posedge REF_CLK) disable iff (RST) SHARED_REQUEST);
endmodule : ipec_ctrl
`default_nettype wire

// ===== sim/ipec_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Core stand-in: takes a presented request after a short service delay
module ipec_core_model #(
  parameter int DELAY = 3
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic irq_valid,
  output var  logic irq_ack
);
  int cnt_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q   <= 0;
      irq_ack <= 1'b0;
    end
    else
    begin
      irq_ack <= irq_valid && (cnt_q == DELAY);
      cnt_q   <= (irq_valid && cnt_q < DELAY) ? cnt_q + 1 : 0;
    end
  end
endmodule : ipec_core_model
`default_nettype wire

// ===== sim/interrupt_priority_edge_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_edge_control_tb;
  import ipec_pkg::*;
  localparam logic [13:0] A_HI = {IPEC_IDX_PRIO_HIGH, 2'b00};
  localparam logic [13:0] A_LO = {IPEC_IDX_PRIO_LOW, 2'b00};
  localparam logic [13:0] A_ES = {IPEC_IDX_EDGE_SEL, 2'b00};
  localparam logic [13:0] A_SS = {IPEC_IDX_SHARED, 2'b00};
  localparam logic [13:0] A_MC = {IPEC_IDX_MASTER, 2'b00};
  localparam logic [13:0] A_ST = {IPEC_IDX_STATUS, 2'b00};
  localparam logic [13:0] A_MK = {IPEC_IDX_MASK, 2'b00};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [13:0] adr = 14'h0000;
  logic [31:0] dat = 32'h0;
  logic [7:0]  pa = 8'h00;
  logic [7:0]  pd = 8'h00;
  logic [3:0]  irq_src;
  logic [3:0]  pc = 4'h0;
  logic        cmp_in = 1'b0;
  logic [2:0]  ins = 3'h0;
  logic [31:0] dat_o;
  logic        ack, irq_ack, irq_valid, shared_req, int_o;
  logic [1:0]  irq_level;
  logic [7:0]  edge_req;
  logic [7:0]  rd;
  int          n_errors = 0;
  int          num_checks = 0;
  int          ecnt = 0;
  int          scnt = 0;

  // 25 MHz reference clock
  always #20 clk = ~clk;
  // Pulse counters let a missed or doubled event show as a count error
  always @(posedge clk) ecnt <= ecnt + int'(edge_req[2] === 1'b1);
  always @(posedge clk) scnt <= scnt + int'(shared_req === 1'b1);

  ipec_ctrl DUT (
    .REF_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(4'hf), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .PORTA_PINS(pa), .PORTD_PINS(pd), .PORTC_PINS(pc), .COMPARATOR_OUT(cmp_in),
    .ENABLE_INTERRUPTS_INSTRUCTION(ins[0]), .DISABLE_INTERRUPTS_INSTRUCTION(ins[1]),
    .INTERRUPT_RETURN_INSTRUCTION(ins[2]), .IRQ_ACK(irq_ack), .IRQ_VALID(irq_valid),
    .IRQ_LEVEL(irq_level), .IRQ_SOURCE(irq_src), .EDGE_REQUESTS(edge_req),
    .SHARED_REQUEST(shared_req), .INT_O(int_o));
  ipec_core_model #(.DELAY(3)) core (.clk(clk), .rst(rst), .irq_valid(irq_valid), .irq_ack(irq_ack));

  task print_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
      n_errors++;
    end
  endtask : check

  // Classic single cycle; the request stands until ack is sampled
  task wb(input logic w, input logic [13:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, 24'h0, d};
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (ack === 1'b1)
        break;
    end
    if (i == 20)
    begin
      n_errors++;
      print_verdict();
    end
    rd = dat_o[7:0];
    {cyc, stb, we} <= 3'b000;
  endtask : wb

  task rdchk(input string name, input logic [13:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    check(name, {24'h0, e}, {24'h0, rd});
  endtask : rdchk

  task pulse(input logic [2:0] v);
    @(posedge clk) ins <= v;
    @(posedge clk) ins <= 3'h0;
  endtask : pulse

  task wait_valid;
    int i;
    for (i = 0; i < 10 && irq_valid !== 1'b1; i++)
      @(posedge clk);
    if (i == 10)
    begin
      n_errors++;
      print_verdict();
    end
  endtask : wait_valid

  task t_reset;
    rdchk("prio_high", A_HI, 8'h00);
    rdchk("prio_low", A_LO, 8'h00);
    rdchk("edge_sel", A_ES, 8'h00);
    rdchk("shared_sel", A_SS, 8'h00);
    rdchk("master", A_MC, 8'h00);
    wb(1'b1, 14'h0004, 8'hff);
    rdchk("unmapped", 14'h0004, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task t_master;
    wb(1'b1, A_HI, 8'h0a);
    rdchk("prio_high", A_HI, 8'h0a);
    wb(1'b1, A_LO, 8'h05);
    rdchk("prio_low", A_LO, 8'h05);
    wb(1'b1, A_MC, 8'hff);
    rdchk("master_wr1", A_MC, 8'h80);
    wb(1'b1, A_MC, 8'h00);
    rdchk("master_wr0", A_MC, 8'h00);
    pulse(3'b001);
    rdchk("master_en", A_MC, 8'h80);
    pulse(3'b010);
    rdchk("master_dis", A_MC, 8'h00);
    pulse(3'b100);
    rdchk("master_ret", A_MC, 8'h80);
    pulse(3'b010);
    $display("test master done");
  endtask : t_master

  // Pins 1 to 3 each get their own level so stale status cannot hide a wrong code
  task t_prio;
    int l;
    logic [7:0] m;
    for (l = 1; l < 4; l++)
    begin
      m = 8'h01 << l;
      wb(1'b1, A_HI, l[1] ? m : 8'h00);
      wb(1'b1, A_LO, l[0] ? m : 8'h00);
      @(posedge clk) pc[l] <= 1'b1;
      repeat (4) @(posedge clk);
      check("valid_gated", 32'h0, {31'h0, irq_valid});
      pulse(3'b001);
      wait_valid();
      check("level", l, {30'h0, irq_level});
      check("source", l, {28'h0, irq_src});
      repeat (6) @(posedge clk);
      rdchk("master_acked", A_MC, 8'h00);
      wb(1'b1, A_ST, m);
    end
    $display("test prio done");
  endtask : t_prio

  task t_int;
    wb(1'b1, A_MK, 8'h00);
    @(posedge clk) pc[0] <= 1'b1;
    repeat (4) @(posedge clk);
    check("int_masked", 32'h0, {31'h0, int_o});
    rdchk("status", A_ST, 8'h01);
    wb(1'b1, A_MK, 8'h01);
    repeat (2) @(posedge clk);
    check("int_set", 32'h1, {31'h0, int_o});
    wb(1'b1, A_ST, 8'h01);
    repeat (2) @(posedge clk);
    check("int_clear", 32'h0, {31'h0, int_o});
    $display("test int done");
  endtask : t_int

  task t_edge;
    int p;
    int e0;
    for (p = 0; p < 2; p++)
    begin
      wb(1'b1, A_ES, p ? 8'h04 : 8'h00);
      e0 = ecnt;
      @(posedge clk) pa[2] <= 1'b1;
      repeat (4) @(posedge clk);
      check("edge_rise", e0 + p, ecnt);
      @(posedge clk) pa[2] <= 1'b0;
      repeat (4) @(posedge clk);
      check("edge_fall", e0 + 1, ecnt);
    end
    // Port D shares the detector with port A; rising polarity still set
    e0 = ecnt;
    @(posedge clk) pd[2] <= 1'b1;
    repeat (4) @(posedge clk);
    check("edge_portd", e0 + 1, ecnt);
    @(posedge clk) pd[2] <= 1'b0;
    repeat (4) @(posedge clk);
    check("edge_portd_fall", e0 + 1, ecnt);
    $display("test edge done");
  endtask : t_edge

  task t_shared;
    int s0;
    wb(1'b1, A_ES, 8'h40);
    s0 = scnt;
    @(posedge clk) cmp_in <= 1'b1;
    repeat (4) @(posedge clk);
    check("shared_cmp_off", s0, scnt);
    @(posedge clk) pa[6] <= 1'b1;
    repeat (4) @(posedge clk);
    check("shared_pin", s0 + 1, scnt);
    @(posedge clk) pa[6] <= 1'b0;
    repeat (4) @(posedge clk);
    // software drops the master enable before switching source
    wb(1'b1, A_MC, 8'h00);
    wb(1'b1, A_SS, 8'h40);
    repeat (4) @(posedge clk);
    check("shared_switch", s0 + 2, scnt);
    @(posedge clk) cmp_in <= 1'b0;
    repeat (4) @(posedge clk);
    @(posedge clk) cmp_in <= 1'b1;
    repeat (4) @(posedge clk);
    check("shared_cmp", s0 + 3, scnt);
    $display("test shared done");
  endtask : t_shared

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_master();
    t_prio();
    t_int();
    t_edge();
    t_shared();
    print_verdict();
  end
endmodule : interrupt_priority_edge_control_tb
`default_nettype wire
